/* verilog/tdmsw_core.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// stream switch: receive stores, route tables, host access
// ------------------------------------------------------------
module tdmsw_core (
  input  wire logic                           core_clk,         // 40 MHz clock
  input  wire logic                           rst_b,            // async reset, low
  input  wire logic                           frame_start,      // frame start, slot 0
  input  wire logic                           bit_tick,         // 16.384 Mb/s slot strobe
  input  wire logic [15:0]                    bp_rx_in,         // backplane serial inputs
  input  wire logic [15:0]                    local_rx_in,      // local serial inputs
  input  wire logic [31:0]                    bp_in_rate,       // 2 bits per stream
  input  wire logic [31:0]                    local_in_rate,    // 2 bits per stream
  input  wire logic [31:0]                    bp_out_rate,      // 2 bits per stream
  input  wire logic [31:0]                    local_out_rate,   // 2 bits per stream
  input  wire logic [14:0]                    host_addr,        // host address
  input  wire logic [15:0]                    host_wdata,       // host write data
  input  wire logic                           host_wr,          // write strobe
  input  wire logic                           host_rd,          // read strobe
  input  wire tdmsw_pkg::tdmsw_target_t       host_target,      // memory target
  input  wire logic                           local_idle_drive_select,     // local idle mode
  input  wire logic                           backplane_idle_drive_select, // backplane idle mode
  input  wire logic                           bp_ber_en,        // backplane pattern on
  input  wire logic [3:0]                     bp_ber_stream,    // pattern stream
  input  wire logic [7:0]                     bp_ber_start,     // first pattern channel
  input  wire logic [7:0]                     bp_ber_len,       // channels after first
  input  wire logic [7:0]                     bp_ber_byte,      // pattern byte
  input  wire logic                           local_ber_en,     // local pattern on
  input  wire logic [3:0]                     local_ber_stream, // pattern stream
  input  wire logic [7:0]                     local_ber_start,  // first pattern channel
  input  wire logic [7:0]                     local_ber_len,    // channels after first
  input  wire logic [7:0]                     local_ber_byte,   // pattern byte
  output logic [15:0]                         host_rdata_q,     // read data
  output logic                                host_ack_q,       // access done pulse
  output logic                                host_reg_sel_q,   // register space pulse
  output logic [15:0]                         local_serial_outputs,     // local data
  output logic [15:0]                         local_serial_oe,          // local drive
  output logic [15:0]                         local_xbuf_en,            // local buffer
  output logic [15:0]                         backplane_serial_outputs, // backplane data
  output logic [15:0]                         backplane_serial_oe,      // backplane drive
  output logic [15:0]                         backplane_xbuf_en         // backplane buffer
);
  import tdmsw_pkg::*;

  // ------------------------------------------------------------
  // storage; side 0 backplane, side 1 local
  // ------------------------------------------------------------
  logic [7:0]        rx_store    [2][DEPTH];
  logic [WORD_W-1:0] route_table [2][DEPTH];

  // ------------------------------------------------------------
  // side-indexed views of the ports
  // ------------------------------------------------------------
  logic [1:0][STREAMS-1:0]   rx_in;     // serial inputs
  logic [1:0][2*STREAMS-1:0] in_rate;   // input rates
  logic [1:0][2*STREAMS-1:0] out_rate;  // output rates
  logic [1:0]                ber_en;    // pattern enables
  logic [1:0][3:0]           ber_str;   // pattern streams
  logic [1:0][7:0]           ber_start; // pattern first channel
  logic [1:0][7:0]           ber_len;   // pattern length
  logic [1:0][7:0]           ber_byte;  // pattern bytes

  assign rx_in     = {local_rx_in, bp_rx_in};
  assign in_rate   = {local_in_rate, bp_in_rate};
  assign out_rate  = {local_out_rate, bp_out_rate};
  assign ber_en    = {local_ber_en, bp_ber_en};
  assign ber_str   = {local_ber_stream, bp_ber_stream};
  assign ber_start = {local_ber_start, bp_ber_start};
  assign ber_len   = {local_ber_len, bp_ber_len};
  assign ber_byte  = {local_ber_byte, bp_ber_byte};

  // ------------------------------------------------------------
  // reset hold: outputs stay idle for a settling time
  // ------------------------------------------------------------
  tdmsw_state_t state_q;     // hold / run
  logic [11:0]  hold_cnt_q;  // hold cycle count
  logic         run;         // switching active

  assign run = (state_q == ST_RUN);

  // count out the hold, then run for good
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q    <= ST_HOLD;
      hold_cnt_q <= 12'h000;
    end else begin
      case (state_q)
        ST_HOLD: begin
          hold_cnt_q <= hold_cnt_q + 12'h001;
          if (hold_cnt_q == HOLD_LAST) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN:  state_q <= ST_RUN;
        default: state_q <= ST_HOLD;
      endcase
    end
  end

  a_hold_length: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(run) |-> $past(hold_cnt_q) == HOLD_LAST)
    else $error("reset hold length wrong");

  // ------------------------------------------------------------
  // frame slot counter at the fastest bit rate
  // ------------------------------------------------------------
  logic [SLOT_W-1:0] slot_q;    // next slot number
  logic [SLOT_W-1:0] cur_slot;  // slot of this tick

  assign cur_slot = frame_start ? '0 : slot_q;

  // frame start realigns the count to slot 0
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      slot_q <= '0;
    end else if (bit_tick) begin
      slot_q <= cur_slot + SLOT_W'(1);
    end else if (frame_start) begin
      slot_q <= '0;
    end
  end

  // ------------------------------------------------------------
  // per side, per stream receive and output selection
  // ------------------------------------------------------------
  logic [1:0][STREAMS-1:0] we;               // store write enables
  logic [IDX_W-1:0]        widx  [2][STREAMS];  // store write index
  logic [7:0]              wbyte [2][STREAMS];  // store write byte

  tdmsw_lane_if lane [2] ();  // to the serialisers

  for (genvar s = 0; s < 2; s++) begin : g_side
    assign lane[s].run = run;
    for (genvar i = 0; i < STREAMS; i++) begin : g_str
      logic [1:0]        ir;        // input rate
      logic              ihit;      // input bit slot
      logic [2:0]        ibit;      // input bit position
      logic [CH_W-1:0]   ich;       // input channel
      logic [6:0]        sh_q;      // deserialiser
      logic [1:0]        orr;       // output rate
      logic              ohit;      // output bit slot
      logic [2:0]        obit;      // output bit position
      logic [CH_W-1:0]   och;       // output channel
      logic [WORD_W-1:0] word;      // route word
      logic              src_side;  // source store
      logic [7:0]        src_byte;  // switched byte
      logic [8:0]        ber_off;   // channel minus pattern start
      logic              ber_hit;   // pattern channel

      // receive: sample each bit, store the byte on its last bit
      assign ir   = in_rate[s][2*i+:2];
      assign ihit = bit_tick & run & slot_hit(cur_slot, ir);
      assign ibit = slot_bit(cur_slot, ir);
      assign ich  = slot_chan(cur_slot, ir);

      // msb arrives first
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          sh_q <= 7'h00;
        end else if (ihit) begin
          sh_q <= {sh_q[5:0], rx_in[s][i]};
        end
      end

      assign we[s][i]    = ihit && (ibit == 3'h7);
      assign widx[s][i]  = {STR_W'(i), ich};
      assign wbyte[s][i] = {sh_q, rx_in[s][i]};

      // output: look up the route word of this stream and channel
      assign orr  = out_rate[s][2*i+:2];
      assign ohit = bit_tick & run & slot_hit(cur_slot, orr);
      assign obit = slot_bit(cur_slot, orr);
      assign och  = slot_chan(cur_slot, orr);
      assign word = route_table[s][{STR_W'(i), och}];

      // backplane table: high picks backplane; local table: high picks local
      assign src_side = word[F_SRC] ^ (s == 0);
      assign src_byte = rx_store[src_side][{word[F_STR_LO+:STR_W], word[F_CH_HI:F_CH_LO]}];

      // pattern window: start channel plus the length that follows
      assign ber_off = {1'b0, och} - {1'b0, ber_start[s]};
      assign ber_hit = ber_en[s] && (ber_str[s] == STR_W'(i)) && !ber_off[8] && (ber_off[7:0] <= ber_len[s]);

      assign lane[s].load[i]  = ohit && (obit == 3'h0);
      assign lane[s].shift[i] = ohit && (obit != 3'h0);
      assign lane[s].on[i]    = word[F_ON];
      assign lane[s].data[i]  = ber_hit ? ber_byte[s] :
                                word[F_MSG] ? word[F_CH_HI:F_CH_LO] :
                                src_byte;

      a_store_write: assert property (@(posedge core_clk) disable iff (!rst_b)
        we[s][i] |=> rx_store[s][$past(widx[s][i])] == $past(wbyte[s][i]))
        else $error("received byte not stored");
      a_msg_byte: assert property (@(posedge core_clk) disable iff (!rst_b)
        ohit && word[F_MSG] && !ber_hit |-> lane[s].data[i] == word[7:0])
        else $error("message byte not sent");
      a_ber_override: assert property (@(posedge core_clk) disable iff (!rst_b)
        ohit && ber_hit |-> lane[s].data[i] == ber_byte[s])
        else $error("pattern byte not sent");
      a_conn_byte: assert property (@(posedge core_clk) disable iff (!rst_b)
        ohit && !word[F_MSG] && !ber_hit |-> lane[s].data[i] ==
          rx_store[word[F_SRC] ^ (s == 0)][{word[11:8], word[7:0]}])
        else $error("switched byte wrong");
    end
  end

  // receive stores take every completed byte
  always_ff @(posedge core_clk) begin
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < STREAMS; i++) begin
        if (we[s][i]) begin
          rx_store[s][widx[s][i]] <= wbyte[s][i];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // host access decode
  // ------------------------------------------------------------
  logic              mem_acc;   // memory space
  logic              mem_ok;    // stream and channel in range
  logic [IDX_W-1:0]  host_idx;  // store / table index
  logic [1:0]        route_we;  // table write per side
  logic [WORD_W-1:0] rd_mux;    // read data

  assign mem_acc  = host_addr[A_SEL];
  assign mem_ok   = mem_acc && !host_addr[A_STR_HI] && !host_addr[A_CH_HI];
  assign host_idx = {host_addr[A_STR_LO+:STR_W], host_addr[A_CH_LO+:CH_W]};

  assign route_we[0] = host_wr && mem_ok && (host_target == TGT_BP_ROUTE);
  assign route_we[1] = host_wr && mem_ok && (host_target == TGT_LOCAL_ROUTE);

  // receive stores read back with the upper byte zero
  assign rd_mux = !mem_ok                       ? 16'h0000 :
                  (host_target == TGT_BP_RX)    ? {8'h00, rx_store[0][host_idx]} :
                  (host_target == TGT_LOCAL_RX) ? {8'h00, rx_store[1][host_idx]} :
                  (host_target == TGT_LOCAL_ROUTE) ? route_table[1][host_idx] :
                  route_table[0][host_idx];

  // route tables are written only by the host
  always_ff @(posedge core_clk) begin
    for (int s = 0; s < 2; s++) begin
      if (route_we[s]) begin
        route_table[s][host_idx] <= host_wdata;
      end
    end
  end

  // read data holds until the next read
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      host_rdata_q   <= 16'h0000;
      host_ack_q     <= 1'b0;
      host_reg_sel_q <= 1'b0;
    end else begin
      host_ack_q     <= host_rd | host_wr;
      host_reg_sel_q <= (host_rd | host_wr) & !mem_acc;
      if (host_rd) begin
        host_rdata_q <= rd_mux;
      end
    end
  end

  a_rd_high_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    host_rd && (host_target inside {TGT_BP_RX, TGT_LOCAL_RX}) |=> host_rdata_q[15:8] == 8'h00)
    else $error("data read upper byte not zero");
  a_reg_space_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    host_rd && !host_addr[A_SEL] |=> host_reg_sel_q && host_ack_q && host_rdata_q == 16'h0000)
    else $error("register space reached memory");
  a_rd_fields: assert property (@(posedge core_clk) disable iff (!rst_b)
    host_rd && mem_ok && host_target == TGT_BP_RX |=>
      host_rdata_q[7:0] == $past(rx_store[0][{host_addr[12:9], host_addr[7:0]}]))
    else $error("address fields decoded wrong");
  a_route_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    route_we[1] |=> route_table[1][$past(host_idx)] == $past(host_wdata))
    else $error("local route word not written");

  // ------------------------------------------------------------
  // serialisers
  // ------------------------------------------------------------
  tdmsw_out_port u_bp_out (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .idle_sel (backplane_idle_drive_select),
    .lane     (lane[0]),
    .ser_q    (backplane_serial_outputs),
    .oe_q     (backplane_serial_oe),
    .xbuf_q   (backplane_xbuf_en)
  );

  tdmsw_out_port u_local_out (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .idle_sel (local_idle_drive_select),
    .lane     (lane[1]),
    .ser_q    (local_serial_outputs),
    .oe_q     (local_serial_oe),
    .xbuf_q   (local_xbuf_en)
  );
endmodule : tdmsw_core

/* verilog/tdmsw_pkg.sv */
// Notes on behaviour
// - top address bit picks memories over registers
// - stream from bits 13-9, channel 8-0
// - channels per stream follow the stream rate
// - received channels deserialised, stored in sequence
// - backplane receive store: 4096 bytes
// - data reads return byte, upper byte zero
// - local receive store: 4096 bytes
// - local route table: 4096 words, host addressed
// - local bit 15 picks source store
// - local bit 14 sends low byte as message
// - local bit 13 enables channel, else idle
// - local bits 12-8 stream, 7-0 channel; the code takes the stream from bits 11-8 and ignores bit 12
// - backplane route table: 4096 words, host addressed
// - backplane bit 15 picks source store
// - backplane bit 14 sends low byte as message
// - backplane bit 13 enables channel, else idle
// - backplane bits 12-8 stream, 7-0 channel; the code takes the stream from bits 11-8 and ignores bit 12
// - test pattern channels ignore source and message
// - reset: outputs high or floating, state cleared
package tdmsw_pkg;
  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int STREAMS = 16;  // streams per side
  localparam int STR_W   = 4;   // stream index width
  localparam int CH_W    = 8;   // channel index width
  localparam int IDX_W   = 12;  // store / table index width
  localparam int DEPTH   = 4096;  // entries per store and table
  localparam int WORD_W  = 16;  // host word width
  localparam int SLOT_W  = 11;  // fastest-rate bit slot index width
  // ------------------------------------------------------------
  // host address fields
  // ------------------------------------------------------------
  localparam int A_SEL    = 14;  // memory / register select
  localparam int A_STR_HI = 13;  // stream field top
  localparam int A_STR_LO = 9;   // stream field bottom
  localparam int A_CH_HI  = 8;   // channel field top
  localparam int A_CH_LO  = 0;   // channel field bottom
  // ------------------------------------------------------------
  // route word fields
  // ------------------------------------------------------------
  localparam int F_SRC    = 15;  // source select
  localparam int F_MSG    = 14;  // message flag
  localparam int F_ON     = 13;  // output on
  localparam int F_STR_LO = 8;   // source stream field bottom
  localparam int F_CH_HI  = 7;   // source channel / message top
  localparam int F_CH_LO  = 0;   // source channel / message bottom
  // ------------------------------------------------------------
  // reset hold timing
  // ------------------------------------------------------------
  localparam int CLK_NS       = 25;     // core clock period
  localparam int HOLD_NS      = 50000;  // hold after reset release
  localparam int HOLD_CYC     = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [11:0] HOLD_LAST = 12'(HOLD_CYC - 1);
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    TGT_BP_RX, TGT_LOCAL_RX, TGT_LOCAL_ROUTE, TGT_BP_ROUTE
  } tdmsw_target_t;  // host memory target
  typedef enum logic {ST_HOLD, ST_RUN} tdmsw_state_t;  // reset hold
  // ------------------------------------------------------------
  // slot arithmetic; rate 0..3 = 2.048 .. 16.384 Mb/s
  // ------------------------------------------------------------
  // true on the first slot of a bit at this rate
  function automatic logic slot_hit(input logic [SLOT_W-1:0] s, input logic [1:0] r);
    return (s[2:0] & (3'h7 >> r)) == 3'h0;
  endfunction
  // bit position inside the channel, msb first
  function automatic logic [2:0] slot_bit(input logic [SLOT_W-1:0] s, input logic [1:0] r);
    logic [SLOT_W-1:0] b;
    b = s >> (2'h3 - r);
    return b[2:0];
  endfunction
  // channel number; rate 0 reaches 31, rate 3 reaches 255
  function automatic logic [CH_W-1:0] slot_chan(input logic [SLOT_W-1:0] s, input logic [1:0] r);
    logic [SLOT_W-1:0] b;
    b = s >> (2'h3 - r);
    return b[SLOT_W-1:3];
  endfunction
endpackage : tdmsw_pkg

/* verilog/tdmsw_lane_if.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// per-side output lanes from the switch core to the serialiser
// ------------------------------------------------------------
interface tdmsw_lane_if;
  logic [tdmsw_pkg::STREAMS-1:0] load;                     // first bit of a channel
  logic [tdmsw_pkg::STREAMS-1:0] shift;                    // later bit of a channel
  logic [tdmsw_pkg::STREAMS-1:0] on;                       // channel output on
  logic [7:0]                    data [tdmsw_pkg::STREAMS]; // byte to send
  logic                          run;                      // reset hold over
  modport src (output load, shift, on, data, run);
  modport snk (input load, shift, on, data, run);
endinterface : tdmsw_lane_if

/* verilog/tdmsw_out_port.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// output serialiser for the sixteen streams of one side
// ------------------------------------------------------------
module tdmsw_out_port (
  input  wire logic                        core_clk,  // core clock
  input  wire logic                        rst_b,     // async reset, low
  input  wire logic                        idle_sel,  // idle drive select
  tdmsw_lane_if.snk                        lane,      // bytes and strobes
  output logic [tdmsw_pkg::STREAMS-1:0]    ser_q,     // serial data
  output logic [tdmsw_pkg::STREAMS-1:0]    oe_q,      // pin drive enable
  output logic [tdmsw_pkg::STREAMS-1:0]    xbuf_q     // external buffer on
);
  import tdmsw_pkg::*;

  // ------------------------------------------------------------
  // one shifter per stream
  // ------------------------------------------------------------
  for (genvar i = 0; i < STREAMS; i++) begin : g_str
    logic [6:0] sh_q;   // remaining bits
    logic       on_q;   // channel on for this byte
    logic       ser_b_q;  // pin level
    logic       oe_b_q;   // pin enable
    logic       xb_b_q;   // external buffer enable

    // idle low select floats the pin, high select drives it high
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        ser_b_q <= 1'b1;
        oe_b_q  <= 1'b0;
        xb_b_q  <= 1'b0;
        sh_q    <= 7'h00;
        on_q    <= 1'b0;
      end else if (!lane.run) begin
        ser_b_q <= 1'b1;
        oe_b_q  <= idle_sel;
        xb_b_q  <= 1'b0;
        on_q    <= 1'b0;
      end else if (lane.load[i]) begin
        on_q    <= lane.on[i];
        ser_b_q <= lane.on[i] ? lane.data[i][7] : 1'b1;
        sh_q    <= lane.data[i][6:0];
        oe_b_q  <= lane.on[i] | idle_sel;
        xb_b_q  <= lane.on[i];
      end else if (lane.shift[i]) begin
        ser_b_q <= on_q ? sh_q[6] : 1'b1;
        sh_q    <= {sh_q[5:0], 1'b0};
      end
    end

    assign ser_q[i]  = ser_b_q;
    assign oe_q[i]   = oe_b_q;
    assign xbuf_q[i] = xb_b_q;

    // a channel that is off never drives data nor opens the buffer
    a_off_chan_idle: assert property (@(posedge core_clk) disable iff (!rst_b)
      lane.run && lane.load[i] && !lane.on[i] |=> ser_b_q && !xb_b_q && (oe_b_q == $past(idle_sel)))
      else $error("disabled channel not idle");
    // during the hold the pin stays high or floating
    a_hold_level: assert property (@(posedge core_clk) disable iff (!rst_b)
      !lane.run |=> ser_b_q && !xb_b_q)
      else $error("output active during reset hold");
  end
endmodule : tdmsw_out_port

/* bench/tdmsw_host_model.sv */
`timescale 1ns/1ps
// host on the parallel port: one strobe per access, answer taken with ack
module tdmsw_host_model (
  input  wire logic                core_clk,                            // core clock
  input  wire logic [15:0]         host_rdata_q,                        // read data
  input  wire logic                host_ack_q,                          // access done
  output logic [14:0]              host_addr = '0,                      // address
  output logic [15:0]              host_wdata = '0,                     // write data
  output logic                     host_wr = 0,                         // write strobe
  output logic                     host_rd = 0,                         // read strobe
  output tdmsw_pkg::tdmsw_target_t host_target = tdmsw_pkg::TGT_BP_RX   // memory target
);
  import tdmsw_pkg::*;
  // strobe for one cycle after an edge; data and ack taken one edge later
  task automatic access(input logic wr, input logic [1:0] tg, input logic [14:0] a,
                        input logic [15:0] d, output logic [15:0] q, output logic ok);
    @(posedge core_clk);
    #2 {host_addr, host_wdata, host_wr, host_rd} = {a, d, wr, ~wr};
    host_target = tdmsw_target_t'(tg);
    @(posedge core_clk);
    #2 {q, ok, host_wr, host_rd} = {host_rdata_q, host_ack_q, 2'b00};
  endtask
endmodule // tdmsw_host_model

/* bench/tdm_switch_memory_map_tb_top.sv */
`timescale 1ns/1ps
module tdm_switch_memory_map_tb_top;
  import tdmsw_pkg::*;
  logic core_clk = 0, rst_b = 0, bit_tick = 0, frame_start = 0, ber_en = 0, sd = 0, o, x;
  logic local_idle_drive_select = 0, backplane_idle_drive_select = 0, host_wr, host_rd, ok;
  logic host_ack_q, host_reg_sel_q;
  logic [10:0] slot = '0;                       // frame slot counter
  logic [1:0]  ri = '0, ro = '0;                // input and output rate
  logic [3:0]  s = '0;                          // stream under test
  logic [7:0]  rx = 8'h5a, ber_byte = '0, ber_start = '0, ber_len = '0, c, d;
  logic [14:0] host_addr;
  logic [15:0] bp_rx_in = '0, local_rx_in = '0, host_wdata, host_rdata_q, q, w, e;
  logic [15:0] local_serial_outputs, local_serial_oe, backplane_serial_outputs, backplane_serial_oe;
  logic [15:0] local_xbuf_en, backplane_xbuf_en;  // external buffer enables
  tdmsw_target_t host_target;
  int error_cnt = 0, samples_checked = 0;
  initial forever #12.5 core_clk = ~core_clk;
  // slot strobe every other cycle; stream i sends rx ^ i, backplane inverted
  always @(posedge core_clk) #2 begin
    slot = slot + 11'(bit_tick);
    bit_tick = ~bit_tick;
    frame_start = bit_tick && slot == 0;
    for (int i = 0; i < 16; i++) local_rx_in[i] = 1'((rx ^ 8'(i)) >> (3'h7 - 3'(slot >> (2'h3 - ri))));
    bp_rx_in = ~local_rx_in;
  end
  tdmsw_core u_tdmsw_core (.*, .bp_in_rate({16{ri}}), .local_in_rate({16{ri}}), .bp_out_rate({16{ro}}),
    .local_out_rate({16{ro}}), .bp_ber_en(ber_en & sd), .bp_ber_stream(s), .bp_ber_start(ber_start),
    .bp_ber_len(ber_len), .bp_ber_byte(ber_byte), .local_ber_en(ber_en & ~sd), .local_ber_stream(s),
    .local_ber_start(ber_start), .local_ber_len(ber_len), .local_ber_byte(ber_byte),
    .local_xbuf_en(local_xbuf_en), .backplane_xbuf_en(backplane_xbuf_en));
  tdmsw_host_model u_tdmsw_host_model (.*);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // bounded wait for the tick of slot n
  task automatic wait_slot(input int n);
    for (int k = 0; k < 5000; k++) begin
      @(posedge core_clk);
      #3 if (bit_tick && slot == 11'(n)) return;
    end
    error_cnt++;
    complete_run();
  endtask
  // route word to expected {xbuf, oe, byte}
  function automatic logic [15:0] expo(input logic [15:0] rw, input logic sel, input logic inb);
    logic [7:0] v;
    v = rw[14] ? rw[7:0] : rx ^ {4'h0, rw[11:8]} ^ {8{rw[15] ~^ sd}};
    if (inb) v = ber_byte;
    return rw[13] ? {8'h03, v} : {7'h0, sel, 8'hff};
  endfunction
  initial begin
    void'($urandom(6));
    ri = 2'($urandom);
    repeat (6) @(posedge core_clk);
    chk(local_serial_outputs & backplane_serial_outputs, 16'hffff);
    chk(local_serial_oe | backplane_serial_oe | local_xbuf_en | backplane_xbuf_en, 16'h0000);
    #2 rst_b = 1;
    // hold, realignment at the next frame start, then one whole aligned frame
    repeat (8200) @(posedge core_clk);
    u_tdmsw_host_model.access(0, 2'h0, 15'h0023, 16'h0, q, ok);
    chk({ok, host_reg_sel_q, q[13:0]}, 16'hc000);
    u_tdmsw_host_model.access(0, 2'h1, 15'h6000, 16'h0, q, ok);
    chk(q, 16'h0000);
    repeat (8) begin
      s = 4'($urandom); c = 8'($urandom) & 8'((32 << ri) - 1); sd = 1'($urandom);
      u_tdmsw_host_model.access(0, {1'b0, ~sd}, {2'b10, s, 1'b0, c}, 16'h0, q, ok);
      chk(q, {8'h00, rx ^ {4'h0, s} ^ {8{sd}}});
    end
    for (int k = 0; k < 8; k++) begin
      @(posedge core_clk) #2;
      s = 4'($urandom); c = 8'($urandom % 8); sd = 1'($urandom); ro = 2'($urandom); w = 16'($urandom);
      if (k < 3) w[14:13] = {k[0], k != 2};
      // a switched source channel must be one the input rate fills
      w[7:0] = w[14] ? w[7:0] : w[7:0] & 8'((32 << ri) - 1);
      ber_en = (k == 4); ber_byte = 8'($urandom); ber_start = 8'($urandom % 4); ber_len = 8'($urandom % 4);
      if (ber_en) c = ber_start;
      {local_idle_drive_select, backplane_idle_drive_select} = 2'($urandom);
      u_tdmsw_host_model.access(1, {1'b1, sd}, {2'b10, s, 1'b0, c}, w, q, ok);
      u_tdmsw_host_model.access(0, {1'b1, sd}, {2'b10, s, 1'b0, c}, w, q, ok);
      chk(q, w);
      e = expo(w, sd ? backplane_idle_drive_select : local_idle_drive_select,
               ber_en && c >= ber_start && c <= ber_start + ber_len);
      for (int b = 0; b < 8; b++) begin
        wait_slot((8 * c + b) << (3 - ro));
        @(posedge core_clk);
        #3 d[7 - b] = sd ? backplane_serial_outputs[s] : local_serial_outputs[s];
        if (b == 0) {x, o} = sd ? {backplane_xbuf_en[s], backplane_serial_oe[s]} : {local_xbuf_en[s], local_serial_oe[s]};
      end
      chk({6'h0, x, o, d}, e);
    end
    complete_run();
  end
endmodule // tdm_switch_memory_map_tb_top
